// >>> core/tmr2_regs.svh
// Purpose : Constants for the second timer module (aux/core timer, capture/reload)
// Assumes : 20 MHz core clock
// Notes   : Definitions only
`ifndef TMR2_REGS_SVH
`define TMR2_REGS_SVH

`define TMR2_WIDTH        16
`define TMR2_BASE_DIV     2
`define TMR2_PRE_BITS     3
`define TMR2_PRE_CNT_BITS 10
`define TMR2_ZERO         16'h0000
`define TMR2_MAX          16'hffff

`endif

// >>> core/tmr2_pkg.sv
// Purpose : Types for the second timer module
// Assumes : Constants live in tmr2_regs.svh
// Notes   : Clock source and edge select encodings
`default_nettype none
`include "tmr2_regs.svh"
package tmr2_pkg;
  typedef enum logic [1:0] {SRC_PRESCALE, SRC_EXT_PIN, SRC_TOGGLE, SRC_OFF} tmr2_src_t;
  typedef enum logic [1:0] {EDGE_NONE, EDGE_RISE, EDGE_FALL, EDGE_BOTH} tmr2_edge_t;

  typedef struct packed {
    logic                      run;
    tmr2_src_t                 src;
    logic [`TMR2_PRE_BITS-1:0] pre;
    logic                      down;
    logic                      extDir;
  } tmr2_tcfg_t;

  typedef struct packed {
    tmr2_edge_t capEdge;
    logic       useFirstClk;
    logic       useFirstDir;
    logic       clearAfterCap;
    logic       reloadOnWrap;
    logic       toggleOutEn;
  } tmr2_ccfg_t;
endpackage
`default_nettype wire

// >>> core/tmr2_edge_sync.sv
// Purpose : Two-stage sampler and edge detector for pin inputs
// Assumes : Pins held at least one sampling period per level
// Notes   : First stage read only by the second stage
`default_nettype none
module tmr2_edge_sync
(
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic pinIn,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else
    begin
      meta_r <= pinIn;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise  = sync_r & ~prev_r;
  assign fall  = ~sync_r & prev_r;
endmodule // tmr2_edge_sync
`default_nettype wire

// >>> core/tmr2_timer_module_two.sv
// Purpose : Second timer module: aux timer, core timer, capture/reload register
// Assumes : Config ports static while timers run; pins synchronous-ish, resampled here
// Notes   : Overview of operation
// Overview of operation
// - Two timers plus capture/reload, prescaled or external clock, finest 2 clocks.
// - Direction set by software or by external direction pin level.
// - Core toggle latch inverts on each core overflow or underflow.
// - Toggle latch clocks aux timer and/or drives the toggle output pin.
// - Core overflow/underflow pulse offered as count clock to compare unit two.
// - Core wrap may reload core timer from capture/reload register.
// - Capture pin transition copies aux timer count into capture/reload register.
// - Optional clear of aux timer after capture, otherwise it keeps counting.
// - First module core clock/direction input edges may also trigger capture.
// - Both timers are sixteen bits wide.
`default_nettype none
`include "tmr2_regs.svh"
module tmr2_timer_module_two
  import tmr2_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   reset_n,
  input  wire tmr2_tcfg_t             auxCfg,
  input  wire tmr2_tcfg_t             coreCfg,
  input  wire tmr2_ccfg_t             capCfg,
  input  wire logic                   auxClkPin,
  input  wire logic                   coreClkPin,
  input  wire logic                   auxDirPin,
  input  wire logic                   coreDirPin,
  input  wire logic                   captureInputPin,
  input  wire logic                   firstCoreClockInput,
  input  wire logic                   firstCoreDirectionInput,
  output logic [`TMR2_WIDTH-1:0]      auxTimer_r,
  output logic [`TMR2_WIDTH-1:0]      coreTimer_r,
  output logic [`TMR2_WIDTH-1:0]      captureReloadReg_r,
  output logic                        coreToggleLatch_r,
  output logic                        toggleOutputPin_r,
  output logic                        coreWrapPulse_r,
  output logic                        captureEvent_r
);
  // --------------------------------------------------------------
  // Input sampling
  // --------------------------------------------------------------
  logic auxClkRise, coreClkRise, capRise, capFall;
  logic fClkRise, fClkFall, fDirRise, fDirFall;
  logic auxDirLvl, coreDirLvl;

  tmr2_edge_sync uAuxClk
  (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .pinIn    (auxClkPin),
    .level    (),
    .rise     (auxClkRise),
    .fall     ()
  );

  tmr2_edge_sync uCoreClk
  (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .pinIn    (coreClkPin),
    .level    (),
    .rise     (coreClkRise),
    .fall     ()
  );

  tmr2_edge_sync uAuxDir
  (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .pinIn    (auxDirPin),
    .level    (auxDirLvl),
    .rise     (),
    .fall     ()
  );

  tmr2_edge_sync uCoreDir
  (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .pinIn    (coreDirPin),
    .level    (coreDirLvl),
    .rise     (),
    .fall     ()
  );

  tmr2_edge_sync uCap
  (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .pinIn    (captureInputPin),
    .level    (),
    .rise     (capRise),
    .fall     (capFall)
  );

  tmr2_edge_sync uFClk
  (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .pinIn    (firstCoreClockInput),
    .level    (),
    .rise     (fClkRise),
    .fall     (fClkFall)
  );

  tmr2_edge_sync uFDir
  (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .pinIn    (firstCoreDirectionInput),
    .level    (),
    .rise     (fDirRise),
    .fall     (fDirFall)
  );

  // --------------------------------------------------------------
  // Prescaler: base tick every 2 clocks, then divide by 2**pre
  // --------------------------------------------------------------
  // Shared by both timers: a new pre value may give one short first period
  logic                           baseTick_r;
  logic [`TMR2_PRE_CNT_BITS-1:0]  preCnt_r;

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      baseTick_r <= 1'b0;
      preCnt_r   <= '0;
    end
    else
    begin
      baseTick_r <= ~baseTick_r;
      if (baseTick_r)
        preCnt_r <= preCnt_r + 1'b1;
    end
  end

  // Tick when all low prescaler bits below the selected stage are ones
  function automatic logic preTick(input logic [`TMR2_PRE_BITS-1:0] pre);
    logic [`TMR2_PRE_CNT_BITS-1:0] mask;
    mask = ({`TMR2_PRE_CNT_BITS{1'b1}} << pre);
    preTick = baseTick_r & ((preCnt_r | mask) == {`TMR2_PRE_CNT_BITS{1'b1}});
  endfunction

  // Direction: pin level overrides when selected, pin high counts down
  function automatic logic isDown(input tmr2_tcfg_t cfg, input logic dirLvl);
    isDown = cfg.extDir ? dirLvl : cfg.down;
  endfunction

  // --------------------------------------------------------------
  // Count enables
  // --------------------------------------------------------------
  logic coreCnt, auxCnt, coreDn, auxDn, coreWrap, capTrig;

  always_comb
  begin
    coreCnt = 1'b0;
    case (coreCfg.src)
      SRC_PRESCALE: coreCnt = preTick(coreCfg.pre);
      SRC_EXT_PIN:  coreCnt = coreClkRise;
      default:      coreCnt = 1'b0;
    endcase
    coreCnt = coreCnt & coreCfg.run;
  end

  always_comb
  begin
    auxCnt = 1'b0;
    case (auxCfg.src)
      SRC_PRESCALE: auxCnt = preTick(auxCfg.pre);
      SRC_EXT_PIN:  auxCnt = auxClkRise;
      SRC_TOGGLE:   auxCnt = coreWrap;
      default:      auxCnt = 1'b0;
    endcase
    auxCnt = auxCnt & auxCfg.run;
  end

  assign coreDn   = isDown(coreCfg, coreDirLvl);
  assign auxDn    = isDown(auxCfg, auxDirLvl);
  assign coreWrap = coreCnt & (coreDn ? (coreTimer_r == `TMR2_ZERO)
                                      : (coreTimer_r == `TMR2_MAX));

  // --------------------------------------------------------------
  // Capture trigger
  // --------------------------------------------------------------
  always_comb
  begin
    capTrig = 1'b0;
    case (capCfg.capEdge)
      EDGE_RISE: capTrig = capRise;
      EDGE_FALL: capTrig = capFall;
      EDGE_BOTH: capTrig = capRise | capFall;
      default:   capTrig = 1'b0;
    endcase
    if (capCfg.useFirstClk && (fClkRise || fClkFall))
      capTrig = 1'b1;
    if (capCfg.useFirstDir && (fDirRise || fDirFall))
      capTrig = 1'b1;
  end

  // --------------------------------------------------------------
  // Core timer and toggle latch
  // --------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      coreTimer_r <= `TMR2_ZERO;
    // Reload takes the place of the wrap value; the latch still toggles
    else if (coreWrap && capCfg.reloadOnWrap)
      coreTimer_r <= captureReloadReg_r;
    else if (coreCnt)
      coreTimer_r <= coreDn ? coreTimer_r - 1'b1 : coreTimer_r + 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      coreToggleLatch_r <= 1'b0;
      toggleOutputPin_r <= 1'b0;
      coreWrapPulse_r   <= 1'b0;
    end
    else
    begin
      if (coreWrap)
        coreToggleLatch_r <= ~coreToggleLatch_r;
      // Pin follows the latch value after this edge; held low when disabled
      toggleOutputPin_r <= capCfg.toggleOutEn & (coreToggleLatch_r ^ coreWrap);
      coreWrapPulse_r   <= coreWrap;
    end
  end

  // --------------------------------------------------------------
  // Aux timer and capture/reload register
  // --------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
      auxTimer_r <= `TMR2_ZERO;
    // Clear wins over a count in the same cycle; the register keeps the old count
    else if (capTrig && capCfg.clearAfterCap)
      auxTimer_r <= `TMR2_ZERO;
    else if (auxCnt)
      auxTimer_r <= auxDn ? auxTimer_r - 1'b1 : auxTimer_r + 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!reset_n)
    begin
      captureReloadReg_r <= `TMR2_ZERO;
      captureEvent_r     <= 1'b0;
    end
    else
    begin
      if (capTrig)
        captureReloadReg_r <= auxTimer_r;
      captureEvent_r <= capTrig;
    end
  end
endmodule // tmr2_timer_module_two
`default_nettype wire

// >>> test/tmr2_sva.sv
// Purpose: Timing checks on the second timer module outputs
// Assumes: Config held while timers run
// Notes: Bound to the design top
`default_nettype none
module tmr2_sva
  import tmr2_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire tmr2_tcfg_t  auxCfg,
  input wire tmr2_tcfg_t  coreCfg,
  input wire tmr2_ccfg_t  capCfg,
  input wire logic        captureInputPin,
  input wire logic [15:0] auxTimer_r,
  input wire logic [15:0] coreTimer_r,
  input wire logic [15:0] captureReloadReg_r,
  input wire logic        coreToggleLatch_r,
  input wire logic        toggleOutputPin_r,
  input wire logic        coreWrapPulse_r,
  input wire logic        captureEvent_r
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wrap_latch_a: assert property
    ($changed(coreToggleLatch_r) |-> coreWrapPulse_r) else $error("no wrap pulse");
  pin_follow_a: assert property
    (capCfg.toggleOutEn && $past(capCfg.toggleOutEn) |-> toggleOutputPin_r == coreToggleLatch_r)
    else $error("pin differs from latch");
  cap_value_a: assert property
    (captureEvent_r |-> captureReloadReg_r == $past(auxTimer_r))
    else $error("wrong captured value");
  cap_clear_a: assert property
    (captureEvent_r && $past(capCfg.clearAfterCap) |-> auxTimer_r == 16'h0000)
    else $error("aux not cleared");
  cap_delay_a: assert property
    (capCfg.capEdge == EDGE_RISE && $rose(captureInputPin) |-> ##3 captureEvent_r)
    else $error("capture late");
  reload_val_a: assert property
    (coreWrapPulse_r && $past(capCfg.reloadOnWrap) |-> coreTimer_r == $past(captureReloadReg_r))
    else $error("wrong reload");
  aux_step_a: assert property
    (auxCfg.run && !auxCfg.extDir && !capCfg.clearAfterCap && $changed(auxTimer_r) |-> auxTimer_r
    == (auxCfg.down ? $past(auxTimer_r) - 16'h0001 : $past(auxTimer_r) + 16'h0001))
    else $error("bad aux step");
  tick_gap_a: assert property
    (coreCfg.src == SRC_PRESCALE && $changed(coreTimer_r) |=> $stable(coreTimer_r))
    else $error("ticks too close");
endmodule // tmr2_sva
bind tmr2_timer_module_two tmr2_sva u_sva (.core_clk, .reset_n, .auxCfg, .coreCfg, .capCfg,
  .captureInputPin, .auxTimer_r, .coreTimer_r, .captureReloadReg_r, .coreToggleLatch_r,
  .toggleOutputPin_r, .coreWrapPulse_r, .captureEvent_r);
`default_nettype wire

// >>> test/tmr2_pins.sv
// Purpose: Pin-side model for clocks, direction and capture inputs
// Assumes: Pins change only at the falling clock edge
// Notes: Bits 0 aux clk, 1 core clk, 2 aux dir, 3 core dir, 4 capture, 5-6 first module
`default_nettype none
module tmr2_pins
(
  input  wire logic  core_clk,
  output logic [6:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pin = 7'h00;
  // Levels held over three clocks so each change is sampled once
  task automatic flip(input int b, input int k);
    repeat (k)
    begin
      @(negedge core_clk);
      pin[b] = ~pin[b];
      repeat (2) @(negedge core_clk);
    end
  endtask
endmodule // tmr2_pins
`default_nettype wire

// >>> test/dual_timer_capture_reload_tb.sv
// Purpose: Self-checking bench for the second timer module
// Assumes: Inputs change at the falling clock edge
// Notes: Core starts at zero, so it counts down to reach a wrap at once
`default_nettype none
module dual_timer_capture_reload_tb
  import tmr2_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'h0;
  logic        reset_n = 1'h0;
  tmr2_tcfg_t  auxCfg = '0;
  tmr2_tcfg_t  coreCfg = '0;
  tmr2_ccfg_t  capCfg = '0;
  wire  [6:0]  pin;
  logic [15:0] aux, cnt, cap, a = 16'h0000, r = 16'h0000;
  logic        tl, tp, wrap;
  int          fails = 0, num_checks = 0, cyc = 0, n;
  tmr2_pins pins (.core_clk, .pin);
  tmr2_timer_module_two DUT (.core_clk, .reset_n, .auxCfg, .coreCfg, .capCfg,
    .auxClkPin(pin[0]), .coreClkPin(pin[1]), .auxDirPin(pin[2]), .coreDirPin(pin[3]),
    .captureInputPin(pin[4]), .firstCoreClockInput(pin[5]), .firstCoreDirectionInput(pin[6]),
    .auxTimer_r(aux), .coreTimer_r(cnt), .captureReloadReg_r(cap), .coreToggleLatch_r(tl),
    .toggleOutputPin_r(tp), .coreWrapPulse_r(wrap), .captureEvent_r());
  initial forever #25 core_clk = ~core_clk;
  task automatic check(input logic [15:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Counts clocks from one wrap pulse to the next
  task automatic waitWrap(output int k);
    k = 0;
    do
    begin
      @(negedge core_clk);
      k++;
    end while (wrap !== 1'h1 && k < 200);
    if (wrap !== 1'h1)
      fails++;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fails++;
      conclude();
    end
  end
  initial
  begin
    repeat (10) @(negedge core_clk);
    reset_n = 1'h1;
    auxCfg.run = 1'h1;
    auxCfg.src = SRC_EXT_PIN;
    for (int e = 0; e < 4; e++)
    begin
      capCfg.capEdge = tmr2_edge_t'(e);
      capCfg.clearAfterCap = (e == 3);
      for (int lv = 1; lv >= 0; lv--)
      begin
        pins.flip(0, 2);
        a++;
        pins.flip(4, 1);
        repeat (6) @(negedge core_clk);
        if (e == 3 || e == 2 - lv)
        begin
          r = a;
          a = (e == 3) ? 16'h0000 : a;
        end
        check(cap, r);
        check(aux, a);
      end
    end
    capCfg.capEdge = EDGE_NONE;
    for (int k = 5; k < 7; k++)
    begin
      capCfg.useFirstClk = (k == 5);
      capCfg.useFirstDir = (k == 6);
      pins.flip(0, 2);
      pins.flip(k, 1);
      repeat (6) @(negedge core_clk);
      check(cap, 16'h0001);
      check(aux, 16'h0000);
    end
    capCfg.clearAfterCap = 1'h0;
    r = 16'h0001;
    auxCfg.extDir = 1'h1;
    pins.flip(2, 1);
    pins.flip(0, 4);
    check(aux, 16'hfffe);
    auxCfg.extDir = 1'h0;
    auxCfg.down = 1'h1;
    pins.flip(0, 2);
    check(aux, 16'hfffd);
    auxCfg.down = 1'h0;
    auxCfg.src = SRC_TOGGLE;
    capCfg.reloadOnWrap = 1'h1;
    capCfg.toggleOutEn = 1'h1;
    coreCfg.run = 1'h1;
    coreCfg.down = 1'h1;
    waitWrap(n);
    check(cnt, r);
    check(16'(tl), 16'h0001);
    check(16'(tp), 16'h0001);
    for (int p = 0; p < 2; p++)
    begin
      coreCfg.pre = 3'(p);
      waitWrap(n);
      waitWrap(n);
      check(16'(n), 16'((r + 16'h0001) << (p + 1)));
    end
    repeat (3) @(negedge core_clk);
    check(aux, 16'h0002);
    check(16'(tl), 16'h0001);
    coreCfg.src = SRC_EXT_PIN;
    coreCfg.down = 1'h0;
    coreCfg.extDir = 1'h1;
    pins.flip(3, 1);
    pins.flip(1, 2);
    check(cnt, 16'h0000);
    pins.flip(1, 2);
    check(cnt, r);
    check(16'(tl), 16'h0000);
    check(aux, 16'h0003);
    conclude();
  end
endmodule // dual_timer_capture_reload_tb
`default_nettype wire
